// ===== logic/tcc_pkg.sv
// Shared constants for the 16-bit timer counter with input capture.
// Assumes one system clock; all users refer to names as tcc_pkg::name.
package tcc_pkg;
  // Counter widths and extreme values
  localparam int          CW         = 16;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;
  // Byte locations on the CPU data bus
  localparam logic [1:0]  ADDR_CNT_LO = 2'h0;
  localparam logic [1:0]  ADDR_CNT_HI = 2'h1;
  localparam logic [1:0]  ADDR_CAP_LO = 2'h2;
  localparam logic [1:0]  ADDR_CAP_HI = 2'h3;
  // Clock select codes
  localparam logic [2:0]  CS_STOP     = 3'h0;
  localparam logic [2:0]  CS_DIV1     = 3'h1;
  localparam logic [2:0]  CS_DIV8     = 3'h2;
  localparam logic [2:0]  CS_DIV64    = 3'h3;
  localparam logic [2:0]  CS_DIV256   = 3'h4;
  localparam logic [2:0]  CS_DIV1024  = 3'h5;
  localparam logic [2:0]  CS_EXT_FALL = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE = 3'h7;
  // Prescaler width and tap masks
  localparam int          PRE_W      = 10;
  localparam logic [9:0]  MASK_8     = 10'h007;
  localparam logic [9:0]  MASK_64    = 10'h03f;
  localparam logic [9:0]  MASK_256   = 10'h0ff;
  localparam logic [9:0]  MASK_1024  = 10'h3ff;
  // Noise filter sample count
  localparam int          FILT_LEN   = 4;
  // Counting sequence classes, Gray ordered
  typedef enum logic [1:0] {
    TCC_NORMAL = 2'b00,
    TCC_CTC    = 2'b01,
    TCC_FAST   = 2'b11,
    TCC_PHASE  = 2'b10
  } tcc_class_e;
  // Mode to counting class; reserved mode 13 counts as normal
  function automatic tcc_class_e tcc_mode_class(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: return TCC_PHASE;
      4'h4, 4'hc:                               return TCC_CTC;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf:             return TCC_FAST;
      default:                                  return TCC_NORMAL;
    endcase
  endfunction
  // Modes where the capture register defines the top value
  function automatic logic tcc_icr_top(input logic [3:0] m);
    return (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
  endfunction
endpackage

// ===== logic/tcc_edge_sampler.sv
// Pin sampler: two-flop synchroniser, optional noise filter, edge pulses.
// Assumes an asynchronous input and a synchronously released reset.
`timescale 1ns/100ps
`default_nettype none
module tcc_edge_sampler #(
  parameter int FLEN = tcc_pkg::FILT_LEN   // Filter sample count
) (
  input  wire logic clk,        // System clock
  input  wire logic rst_n,      // Synchronised reset, active low
  input  wire logic din,        // Raw asynchronous input
  input  wire logic enable,     // Filter and detector active
  input  wire logic filter_en,  // Noise filter on
  output logic      rise,       // One-cycle rising pulse
  output logic      fall        // One-cycle falling pulse
);
  // All sampler state
  typedef struct packed {
    logic            sync1;  // First synchroniser stage
    logic            sync2;  // Second synchroniser stage
    logic [FLEN-1:0] hist;   // Recent samples, newest at bit 0
    logic            lvl;    // Level seen by the edge detector
    logic            rise;   // Registered rising pulse
    logic            fall;   // Registered falling pulse
  } tcc_smp_s;

  tcc_smp_s s, next_s;

  // Next state; the pin is sampled whatever its direction
  always_comb begin
    next_s       = s;
    next_s.sync1 = din;
    next_s.sync2 = s.sync1;
    next_s.rise  = 1'b0;
    next_s.fall  = 1'b0;
    // Held while disabled; a level change meanwhile gives an edge on re-enable
    if (enable) begin
      next_s.hist = {s.hist[FLEN-2:0], s.sync2};
      if (!filter_en) begin
        next_s.lvl = s.sync2;
      end else if (&s.hist || ~|s.hist) begin
        next_s.lvl = s.hist[FLEN-1];  // All samples agree
      end
      next_s.rise = next_s.lvl & ~s.lvl;  // Same detector for all
      next_s.fall = ~next_s.lvl & s.lvl;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = s.rise;
  assign fall = s.fall;

  // Filtered level moves only after a full run of equal samples
  a_filter_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (filter_en && enable && s.lvl != s.hist[FLEN-1]
     && !(&s.hist || ~|s.hist)) |=> $stable(s.lvl))
    else $error("filtered level moved on unequal samples");
endmodule
`default_nettype wire

// ===== logic/tcc_tick_gen.sv
// Clock select: prescaler taps or external pin edges to a tick enable.
// Assumes external edges come already synchronised from a sampler.
`timescale 1ns/100ps
`default_nettype none
module tcc_tick_gen (
  input  wire logic       clk,        // System clock
  input  wire logic       rst_n,      // Synchronised reset, active low
  input  wire logic [2:0] clock_sel,  // Clock source code
  input  wire logic       ext_rise,   // External pin rising pulse
  input  wire logic       ext_fall,   // External pin falling pulse
  output logic            tick        // Timer tick enable pulse
);
  // All tick state
  typedef struct packed {
    logic [tcc_pkg::PRE_W-1:0] div;   // Free running prescaler
    logic                      tick;  // Registered tick
  } tcc_tick_s;

  tcc_tick_s s, next_s;

  // Prescaler runs free so taps stay aligned across source changes
  always_comb begin
    next_s     = s;
    next_s.div = s.div + 10'h001;
    case (clock_sel)
      tcc_pkg::CS_DIV1:     next_s.tick = 1'b1;
      tcc_pkg::CS_DIV8:
        next_s.tick = (s.div & tcc_pkg::MASK_8) == tcc_pkg::MASK_8;
      tcc_pkg::CS_DIV64:
        next_s.tick = (s.div & tcc_pkg::MASK_64) == tcc_pkg::MASK_64;
      tcc_pkg::CS_DIV256:
        next_s.tick = (s.div & tcc_pkg::MASK_256) == tcc_pkg::MASK_256;
      tcc_pkg::CS_DIV1024:
        next_s.tick = s.div == tcc_pkg::MASK_1024;
      tcc_pkg::CS_EXT_FALL: next_s.tick = ext_fall;
      tcc_pkg::CS_EXT_RISE: next_s.tick = ext_rise;
      default:              next_s.tick = 1'b0;  // Stopped
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  // No tick one cycle after the stop code
  a_stop_silent: assert property (@(posedge clk) disable iff (!rst_n)
    clock_sel == tcc_pkg::CS_STOP |=> !tick)
    else $error("tick while clock stopped");
endmodule
`default_nettype wire

// ===== logic/tcc_timer.sv
// Sixteen-bit timer counter with input capture, byte-wide CPU access.
// Assumes a CPU strobing one byte access per cycle on mclk; compare
// units and interrupt controller sit outside and use the outputs.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer (
  input  wire logic        mclk,                    // System clock
  input  wire logic        nrst,                    // Async reset, low
  input  wire logic [2:0]  clock_sel,               // Clock source
  input  wire logic [3:0]  waveform_mode,           // Counting mode
  input  wire logic        filter_en,               // Noise filter on
  input  wire logic        capture_edge_sel,        // 1 rising capture
  input  wire logic        comparator_capture_sel,  // Comparator source
  input  wire logic        comparator_out,          // Comparator level
  input  wire logic        capture_pin,             // Capture pin
  input  wire logic        ext_clock_pin,           // External clock
  input  wire logic [15:0] compare_top,             // Top from compare A
  input  wire logic        capture_irq_en,          // Capture irq enable
  input  wire logic        overflow_irq_en,         // Overflow irq en
  input  wire logic        capture_flag_clr,        // Write-one clear
  input  wire logic        capture_irq_ack,         // Irq taken, clear
  input  wire logic        overflow_flag_clr,       // Write-one clear
  input  wire logic        overflow_irq_ack,        // Irq taken, clear
  input  wire logic [1:0]  cpu_addr,                // Byte location
  input  wire logic        cpu_wr,                  // Write strobe
  input  wire logic        cpu_rd,                  // Read strobe
  input  wire logic [7:0]  cpu_wdata,               // Write byte
  output logic      [7:0]  cpu_rdata,               // Read byte
  output logic      [15:0] count_value,             // Counter
  output logic      [15:0] capture_value,           // Capture register
  output logic             count_dir,               // 1 counting up
  output logic             top_hit,                 // Counter at top
  output logic             bottom_hit,              // Counter at zero
  output logic             timer_tick,              // Tick pulse
  output logic             overflow_flag,           // Overflow flag
  output logic             capture_flag,            // Capture flag
  output logic             overflow_irq,            // Overflow request
  output logic             capture_irq              // Capture request
);
  // All timer state
  typedef struct packed {
    logic [15:0] cnt;    // Counter
    logic [15:0] cap;    // Capture register
    logic [7:0]  temp;   // Shared high-byte latch
    logic [7:0]  rdata;  // Read data
    logic        dir;    // Count direction
    logic        top;    // At top
    logic        bot;    // At bottom
    logic        ovf;    // Overflow flag
    logic        capf;   // Capture flag
    logic        ovi;    // Overflow request
    logic        capi;   // Capture request
  } tcc_state_s;

  tcc_state_s s, next_s;
  logic [1:0] rst_pipe;    // Reset release stages
  logic       rst_n;       // Synchronised reset
  logic       tick;        // Timer tick
  logic       ext_rise;    // External clock rising
  logic       ext_fall;    // External clock falling
  logic       cap_rise;    // Capture source rising
  logic       cap_fall;    // Capture source falling
  logic       cap_src;     // Selected capture source
  logic       cap_ev;      // Qualified capture event
  logic       icr_top;     // Capture register is top
  logic       wr_cnt_lo;   // Counter low write
  logic       wr_cap_lo;   // Capture low write
  logic [15:0] top_val;    // Current top value
  tcc_pkg::tcc_class_e cls;  // Counting class

  // Reset released through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Source mux ahead of the synchroniser; a switch may capture
  assign cap_src = comparator_capture_sel ? comparator_out : capture_pin;
  assign cls     = tcc_pkg::tcc_mode_class(waveform_mode);
  assign icr_top = tcc_pkg::tcc_icr_top(waveform_mode);
  assign cap_ev  = capture_edge_sel ? cap_rise : cap_fall;
  assign wr_cnt_lo = cpu_wr && cpu_addr == tcc_pkg::ADDR_CNT_LO;
  assign wr_cap_lo = cpu_wr && cpu_addr == tcc_pkg::ADDR_CAP_LO;

  // External clock pin sampler, no filter
  tcc_edge_sampler u_ext (
    .clk       (mclk),
    .rst_n     (rst_n),
    .din       (ext_clock_pin),
    .enable    (1'b1),
    .filter_en (1'b0),
    .rise      (ext_rise),
    .fall      (ext_fall)
  );

  // Capture sampler, same logic as the clock pin
  tcc_edge_sampler u_cap (
    .clk       (mclk),
    .rst_n     (rst_n),
    .din       (cap_src),
    .enable    (!icr_top),
    .filter_en (filter_en),
    .rise      (cap_rise),
    .fall      (cap_fall)
  );

  // Tick source selection
  tcc_tick_gen u_tick (
    .clk       (mclk),
    .rst_n     (rst_n),
    .clock_sel (clock_sel),
    .ext_rise  (ext_rise),
    .ext_fall  (ext_fall),
    .tick      (tick)
  );

  // Top value by mode; fixed tops for the 8/9/10-bit modes
  always_comb begin
    case (waveform_mode)
      4'h1, 4'h5:             top_val = tcc_pkg::TOP_8BIT;
      4'h2, 4'h6:             top_val = tcc_pkg::TOP_9BIT;
      4'h3, 4'h7:             top_val = tcc_pkg::TOP_10BIT;
      4'h8, 4'ha, 4'hc, 4'he: top_val = s.cap;
      4'h4, 4'h9, 4'hb, 4'hf: top_val = compare_top;
      default:                top_val = tcc_pkg::CNT_MAX;
    endcase
  end

  // Next state of counter, latch, capture and flags
  always_comb begin
    next_s = s;
    // Byte reads; a low read loads the latch
    if (cpu_rd) begin
      case (cpu_addr)
        tcc_pkg::ADDR_CNT_LO: begin
          next_s.rdata = s.cnt[7:0];
          next_s.temp  = s.cnt[15:8];
        end
        tcc_pkg::ADDR_CAP_LO: begin
          next_s.rdata = s.cap[7:0];
          next_s.temp  = s.cap[15:8];
        end
        default: next_s.rdata = s.temp;  // High bytes come from latch
      endcase
    end
    // High byte writes land in the shared latch only
    if (cpu_wr && (cpu_addr == tcc_pkg::ADDR_CNT_HI ||
                   cpu_addr == tcc_pkg::ADDR_CAP_HI)) begin
      next_s.temp = cpu_wdata;
    end
    // Overflow clear ahead of counting so a new overflow wins
    if (overflow_flag_clr || overflow_irq_ack) begin
      next_s.ovf = 1'b0;
    end
    // Counting sequence on each tick
    if (tick) begin
      case (cls)
        tcc_pkg::TCC_PHASE: begin
          if (s.dir) begin
            if (s.cnt >= top_val) begin
              next_s.dir = 1'b0;  // Turn at top
              next_s.cnt = s.cnt - tcc_pkg::CNT_ONE;
            end else begin
              next_s.cnt = s.cnt + tcc_pkg::CNT_ONE;
            end
          end else if (s.cnt == tcc_pkg::CNT_BOTTOM) begin
            next_s.dir = 1'b1;  // Turn at bottom, overflow there
            next_s.cnt = s.cnt + tcc_pkg::CNT_ONE;
            next_s.ovf = 1'b1;
          end else begin
            next_s.cnt = s.cnt - tcc_pkg::CNT_ONE;
          end
        end
        tcc_pkg::TCC_FAST: begin
          next_s.dir = 1'b1;
          if (s.cnt == top_val) begin
            next_s.cnt = tcc_pkg::CNT_BOTTOM;  // Clear at top
            next_s.ovf = 1'b1;
          end else begin
            next_s.cnt = s.cnt + tcc_pkg::CNT_ONE;
          end
        end
        tcc_pkg::TCC_CTC: begin
          next_s.dir = 1'b1;
          // Counter above a lowered top runs on to max and wraps
          if (s.cnt == top_val) begin
            next_s.cnt = tcc_pkg::CNT_BOTTOM;
          end else begin
            next_s.cnt = s.cnt + tcc_pkg::CNT_ONE;
          end
          if (s.cnt == tcc_pkg::CNT_MAX) begin
            next_s.ovf = 1'b1;
          end
        end
        default: begin
          next_s.dir = 1'b1;
          next_s.cnt = s.cnt + tcc_pkg::CNT_ONE;
          if (s.cnt == tcc_pkg::CNT_MAX) begin
            next_s.ovf = 1'b1;
          end
        end
      endcase
    end
    // CPU write wins, with or without a running tick
    if (wr_cnt_lo) begin
      next_s.cnt = {s.temp, cpu_wdata};
    end
    // Capture overwrites unread values
    if (cap_ev) begin
      next_s.cap = s.cnt;
    end else if (wr_cap_lo && icr_top) begin
      next_s.cap = {s.temp, cpu_wdata};
    end
    // Flags: clear first so a same-cycle event wins
    if (capture_flag_clr || capture_irq_ack) begin
      next_s.capf = 1'b0;
    end
    if (cap_ev) begin
      next_s.capf = 1'b1;
    end
    next_s.capi = next_s.capf && capture_irq_en;
    next_s.ovi  = next_s.ovf && overflow_irq_en;
    next_s.top  = next_s.cnt == top_val;
    next_s.bot  = next_s.cnt == tcc_pkg::CNT_BOTTOM;
  end

  // State register; direction starts up
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s     <= '0;
      s.dir <= 1'b1;
      s.bot <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops
  assign cpu_rdata     = s.rdata;
  assign count_value   = s.cnt;
  assign capture_value = s.cap;
  assign count_dir     = s.dir;
  assign top_hit       = s.top;
  assign bottom_hit    = s.bot;
  assign timer_tick    = tick;
  assign overflow_flag = s.ovf;
  assign capture_flag  = s.capf;
  assign overflow_irq  = s.ovi;
  assign capture_irq   = s.capi;

  // Checks on the design's own outputs and internal signals
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_stop_hold: assert property (
    (clock_sel == tcc_pkg::CS_STOP && $past(clock_sel) == tcc_pkg::CS_STOP
     && !wr_cnt_lo) |=> $stable(count_value))
    else $error("counter moved while stopped");

  a_step_one: assert property (
    (tick && !wr_cnt_lo && cls == tcc_pkg::TCC_NORMAL
     && count_value != tcc_pkg::CNT_MAX)
    |=> count_value == $past(count_value) + tcc_pkg::CNT_ONE)
    else $error("normal count did not step by one");

  a_write_wins: assert property (
    wr_cnt_lo |=> count_value == {$past(s.temp), $past(cpu_wdata)})
    else $error("counter write lost");

  a_low_read_latch: assert property (
    (cpu_rd && cpu_addr == tcc_pkg::ADDR_CNT_LO) ##1
    (cpu_rd && cpu_addr == tcc_pkg::ADDR_CNT_HI && !cpu_wr)
    |=> cpu_rdata == $past(count_value[15:8], 2))
    else $error("high byte not from latched counter");

  a_ovf_normal: assert property (
    (tick && !wr_cnt_lo && cls == tcc_pkg::TCC_NORMAL
     && count_value == tcc_pkg::CNT_MAX) |=> overflow_flag)
    else $error("overflow flag missing at wrap");

  a_capture_copy: assert property (
    cap_ev |=> capture_value == $past(count_value) && capture_flag)
    else $error("capture value or flag wrong");

  a_irq_masked: assert property (
    !capture_irq_en |=> !capture_irq)
    else $error("capture request while disabled");

  a_cap_read: assert property (
    (cpu_rd && cpu_addr == tcc_pkg::ADDR_CAP_LO)
    |=> s.temp == $past(capture_value[15:8])
        && cpu_rdata == $past(capture_value[7:0]))
    else $error("capture low read did not latch");

  a_cap_wr_lock: assert property (
    (wr_cap_lo && !icr_top && !cap_ev) |=> $stable(capture_value))
    else $error("capture written outside capture-top mode");

  a_gate_off: assert property (
    (icr_top && $past(icr_top)) |-> !cap_ev)
    else $error("capture event in capture-top mode");

  c_capture: cover property (cap_ev ##1 capture_flag);
  c_overflow: cover property (tick ##1 overflow_flag);
  c_turn_down: cover property (count_dir ##1 !count_dir);
  c_latch_write: cover property (cpu_wr ##1 wr_cnt_lo);
endmodule
`default_nettype wire

// ===== sim/tcc_cpu_model.sv
// CPU core model: byte reads and writes on the timer's 8-bit bus.
// Assumes the bench top is tcc_timer_tb and offers a check task.
`timescale 1ns/100ps
`default_nettype none
module tcc_cpu_model (
  input  wire logic       mclk,      // System clock
  input  wire logic [7:0] cpu_rdata, // Read byte
  output logic      [1:0] cpu_addr,  // Byte location
  output logic            cpu_wr,    // Write strobe
  output logic            cpu_rd,    // Read strobe
  output logic      [7:0] cpu_wdata  // Write byte
);
  logic [7:0] exp_q[$];  // Expected read bytes, oldest first
  initial begin
    cpu_addr = 2'h0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'h00;
  end
  // One write byte; strobe stays up until idle or the next access
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge mclk);
    cpu_rd = 1'b0;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
  endtask
  // One read byte; the expected byte is noted for the monitor
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(negedge mclk);
    cpu_wr = 1'b0;
    cpu_addr = a;
    cpu_rd = 1'b1;
    exp_q.push_back(e);
  endtask
  // Strobes dropped after their rising edge; stale data inverted
  task automatic idle;
    @(negedge mclk);
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = ~cpu_wdata;
  endtask
  // Back to back: high byte first on write, low byte first on read
  task automatic wr16(input logic [1:0] lo, input logic [15:0] v);
    wr(lo + 2'h1, v[15:8]);
    wr(lo, v[7:0]);
    idle();
  endtask
  task automatic rd16(input logic [1:0] lo, input logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 2'h1, v[15:8]);
    idle();
  endtask
  // Read data is checked one time unit after the edge that takes the read
  always @(posedge mclk) begin
    if (cpu_rd === 1'b1) begin
      #1;
      tcc_timer_tb.check(16'(cpu_rdata), 16'(exp_q.pop_front()));
    end
  end
endmodule
`default_nettype wire

// ===== sim/tcc_timer_tb.sv
// Self-checking bench for the timer counter with input capture.
// Assumes tcc_timer and tcc_cpu_model; inputs move on falling edges.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_tb;
  logic mclk, nrst, filter_en, capture_edge_sel, comparator_capture_sel;
  logic comparator_out, capture_pin, capture_irq_en, overflow_irq_en;
  logic ext_clock_pin;        // External clock pin
  logic capture_flag_clr, capture_irq_ack, overflow_flag_clr;
  logic overflow_irq_ack, cpu_wr, cpu_rd, count_dir, top_hit, bottom_hit;
  logic timer_tick, overflow_flag, capture_flag, overflow_irq, capture_irq;
  logic [2:0]  clock_sel;     // Tick source
  logic [3:0]  waveform_mode; // Counting mode
  logic [1:0]  cpu_addr;      // Byte location
  logic [7:0]  cpu_wdata, cpu_rdata;
  logic [15:0] count_value, capture_value, v, w;
  logic [15:0] cap_q[$];      // Expected capture stamps
  int          err_total, cmp_count;
  tcc_timer tcc_timer_i (.mclk(mclk), .nrst(nrst), .clock_sel(clock_sel),
    .waveform_mode(waveform_mode), .filter_en(filter_en),
    .capture_edge_sel(capture_edge_sel), .capture_pin(capture_pin),
    .comparator_capture_sel(comparator_capture_sel),
    .comparator_out(comparator_out), .ext_clock_pin(ext_clock_pin),
    .compare_top(16'h1234), .capture_irq_en(capture_irq_en),
    .overflow_irq_en(overflow_irq_en), .capture_flag_clr(capture_flag_clr),
    .capture_irq_ack(capture_irq_ack), .overflow_irq_ack(overflow_irq_ack),
    .overflow_flag_clr(overflow_flag_clr), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .count_value(count_value),
    .capture_value(capture_value), .count_dir(count_dir),
    .top_hit(top_hit), .bottom_hit(bottom_hit), .timer_tick(timer_tick),
    .overflow_flag(overflow_flag), .capture_flag(capture_flag),
    .overflow_irq(overflow_irq), .capture_irq(capture_irq));
  tcc_cpu_model tcc_cpu_model_i (.mclk(mclk), .cpu_rdata(cpu_rdata),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata));
  // Single comparison point for every result
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Drive the capture pin, then let sync, filter and detector run
  task automatic pin(input logic lvl, input int n);
    @(negedge mclk) capture_pin = lvl;
    repeat (n) @(negedge mclk);
  endtask
  // Capture flag clear strobe, one cycle wide
  task automatic clr_cap;
    @(negedge mclk) capture_flag_clr = 1'b1;
    @(negedge mclk) capture_flag_clr = 1'b0;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Capture monitor: oldest stamp checked when the flag rises
  always @(posedge capture_flag) begin
    #1;
    if (cap_q.size() == 0) check(16'h0001, 16'h0000);
    else check(capture_value, cap_q.pop_front());
  end
  // Watchdog well beyond the expected run length
  initial begin
    #100us;
    err_total++;
    complete_run();
  end
  initial begin
    {nrst, filter_en, capture_edge_sel, comparator_capture_sel} = 4'h0;
    {comparator_out, capture_pin, capture_irq_en, overflow_irq_en} = 4'h0;
    {capture_flag_clr, capture_irq_ack, overflow_flag_clr} = 3'h0;
    {overflow_irq_ack, ext_clock_pin} = 2'h0;
    clock_sel = tcc_pkg::CS_STOP;
    waveform_mode = 4'h0;
    v = 16'($urandom(48));
    repeat (5) @(posedge mclk);
    @(negedge mclk) nrst = 1'b1;
    repeat (3) @(negedge mclk);
    check(16'({count_dir, bottom_hit, capture_flag}), 16'h0006);
    // Stopped counter: write, hold, read back, then stamp it
    v = 16'($urandom());
    tcc_cpu_model_i.wr16(tcc_pkg::ADDR_CNT_LO, v);
    repeat (4) @(negedge mclk);
    tcc_cpu_model_i.rd16(tcc_pkg::ADDR_CNT_LO, v);
    capture_edge_sel = 1'b1;
    capture_irq_en = 1'b1;
    cap_q.push_back(v);
    pin(1'b1, 8);
    check(16'({capture_flag, capture_irq}), 16'h0003);
    tcc_cpu_model_i.rd16(tcc_pkg::ADDR_CAP_LO, v);
    @(negedge mclk) capture_irq_ack = 1'b1;
    @(negedge mclk) capture_irq_ack = 1'b0;
    pin(1'b0, 8);
    check(16'(capture_flag), 16'h0000);
    // Falling select, then a second stamp over an unread one
    capture_edge_sel = 1'b0;
    w = ~v;
    tcc_cpu_model_i.wr16(tcc_pkg::ADDR_CNT_LO, w);
    cap_q.push_back(w);
    pin(1'b1, 8);
    pin(1'b0, 8);
    tcc_cpu_model_i.wr16(tcc_pkg::ADDR_CNT_LO, v);
    pin(1'b1, 8);
    pin(1'b0, 8);
    check(capture_value, v);
    clr_cap();
    check(16'(capture_flag), 16'h0000);
    // Filter: short pulse ignored, long level captured late
    filter_en = 1'b1;
    capture_edge_sel = 1'b1;
    pin(1'b1, 2);
    pin(1'b0, 12);
    check(16'(capture_flag), 16'h0000);
    cap_q.push_back(v);
    pin(1'b1, 6);
    check(16'(capture_flag), 16'h0000);
    repeat (6) @(negedge mclk);
    check(16'(capture_flag), 16'h0001);
    clr_cap();
    filter_en = 1'b0;
    pin(1'b0, 8);
    // Comparator as source; flag cleared after the switch
    comparator_capture_sel = 1'b1;
    clr_cap();
    cap_q.push_back(v);
    @(negedge mclk) comparator_out = 1'b1;
    repeat (8) @(negedge mclk);
    check(16'(capture_flag), 16'h0001);
    clr_cap();
    comparator_out = 1'b0;
    comparator_capture_sel = 1'b0;
    repeat (8) @(negedge mclk);
    // Capture register as top: writable, input frozen
    waveform_mode = 4'hc;
    w = 16'($urandom());
    tcc_cpu_model_i.wr16(tcc_pkg::ADDR_CAP_LO, w);
    check(capture_value, w);
    // Latch still holds the high byte; one low write sets the counter
    tcc_cpu_model_i.wr(tcc_pkg::ADDR_CNT_LO, w[7:0]);
    tcc_cpu_model_i.idle();
    check(16'(top_hit), 16'h0001);
    pin(1'b1, 8);
    pin(1'b0, 8);
    check(16'(capture_flag), 16'h0000);
    waveform_mode = 4'h0;
    tcc_cpu_model_i.wr16(tcc_pkg::ADDR_CAP_LO, ~w);
    check(capture_value, w);
    // Normal mode run across 0xffff: ten ticks at full rate
    tcc_cpu_model_i.wr16(tcc_pkg::ADDR_CNT_LO, 16'hfffd);
    overflow_irq_en = 1'b1;
    clock_sel = tcc_pkg::CS_DIV1;
    repeat (10) @(negedge mclk);
    check(16'(timer_tick), 16'h0001);
    clock_sel = tcc_pkg::CS_STOP;
    repeat (4) @(negedge mclk);
    tcc_cpu_model_i.rd16(tcc_pkg::ADDR_CNT_LO, 16'h0007);
    check(16'({overflow_flag, overflow_irq}), 16'h0003);
    @(negedge mclk) overflow_flag_clr = 1'b1;
    @(negedge mclk) overflow_flag_clr = 1'b0;
    @(negedge mclk);
    check(16'({overflow_flag, overflow_irq}), 16'h0000);
    // External rising edges clock the counter, three pulses
    tcc_cpu_model_i.wr16(tcc_pkg::ADDR_CNT_LO, v);
    clock_sel = tcc_pkg::CS_EXT_RISE;
    repeat (3) begin
      @(negedge mclk) ext_clock_pin = 1'b1;
      repeat (3) @(negedge mclk);
      @(negedge mclk) ext_clock_pin = 1'b0;
      repeat (3) @(negedge mclk);
    end
    clock_sel = tcc_pkg::CS_STOP;
    repeat (4) @(negedge mclk);
    tcc_cpu_model_i.rd16(tcc_pkg::ADDR_CNT_LO, v + 16'h0003);
    complete_run();
  end
endmodule
`default_nettype wire
